// *** iop_port_regs.sv ***
`timescale 1ns/10ps
// Notes on behaviour
// - Ports A and B: mode bit 0 is MCU I/O, 1 is latched address out.
// - Mode, direction and drive registers reset to zero.
// - Bit n of every port register governs pin n of that port.
// - Direction 1 makes an output, 0 an input; input after reset.
// - Ports A, B, C drive when direction bit or PLD enable is 1.
// - Port D direction holds only its three low bits.
// - Open-drain bits: 1 is open drain, 0 push-pull (default).
// - Slew bits: 1 is fast slew, 0 slow slew (default).
// - Ports A and B: drive bits 3..0 slew, bits 7..4 open drain.
// - Port C drive bits all open drain; port D bits 2..0 slew.
// - Data-in read returns pin levels after the two-flop synchroniser.
// - Data-out stores writes, drives enabled pins, reads back.
// - Output macrocell read returns cells; write loads unmasked cells.
// - Mask bit 1 blocks MCU loads of its macrocell; resets to 0.
// - Input macrocells store pins, feed PLD bus, read by MCU.
// - Enable status reads 1 for enabled pin, 0 for disabled; port D reads 0.
// - Ports C and D have no mode register nor address out.
// - MCU reaches registers by plain bus cycles at fixed offsets.
// - Port C pins may carry the serial test/programming port.
// - Group AB routes to ports A or B, group BC to B or C.
// - Pin C7 may be byte-enable input; C4 a battery indicator.
module iop_port_regs (
    input wire logic mclk,
    input wire logic reset,
    input wire logic io_register_block_select,
    input wire logic [7:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    input wire logic [7:0] port_a_pin_in,
    input wire logic [7:0] port_b_pin_in,
    input wire logic [7:0] port_c_pin_in,
    input wire logic [2:0] port_d_pin_in,
    output logic [7:0] port_a_pin_out,
    output logic [7:0] port_b_pin_out,
    output logic [7:0] port_c_pin_out,
    output logic [2:0] port_d_pin_out,
    output logic [7:0] port_a_pin_oe,
    output logic [7:0] port_b_pin_oe,
    output logic [7:0] port_c_pin_oe,
    output logic [2:0] port_d_pin_oe,
    output logic [7:0] port_a_fast_slew,
    output logic [7:0] port_b_fast_slew,
    output logic [2:0] port_d_fast_slew,
    input wire logic [7:0] pld_oe_a,
    input wire logic [7:0] pld_oe_b,
    input wire logic [7:0] pld_oe_c,
    input wire logic [2:0] pld_oe_d,
    input wire logic [7:0] lat_addr_a,
    input wire logic [7:0] lat_addr_b,
    input wire logic [7:0] pld_ab_next,
    input wire logic pld_ab_load,
    input wire logic [7:0] pld_bc_next,
    input wire logic pld_bc_load,
    input wire logic [7:0] route_ab_to_a,
    input wire logic [7:0] route_ab_to_b,
    input wire logic [7:0] route_bc_to_b,
    input wire logic [7:0] route_bc_to_c,
    input wire logic imc_latch_en,
    output logic [23:0] input_macrocell_bus,
    output logic [7:0] macrocell_group_ab,
    output logic [7:0] macrocell_group_bc,
    input wire logic jtag_enable,
    input wire logic [7:0] jtag_out,
    input wire logic [7:0] jtag_oe,
    output logic [7:0] jtag_in,
    input wire logic dbe_enable,
    output logic port_c_pin_seven,
    input wire logic batt_ind_enable,
    input wire logic supply_below_battery
);
    logic [3:0][7:0] pin_raw;
    logic [3:0][7:0] sync1_r;
    logic [3:0][7:0] sync2_r;
    logic [3:0][7:0] mode_r;
    logic [3:0][7:0] dir_r;
    logic [3:0][7:0] drive_r;
    logic [3:0][7:0] dout_r;
    logic [3:0][7:0] imc_r;
    logic [3:0][7:0] pld_oe;
    logic [3:0][7:0] lat_addr;
    logic [3:0][7:0] en_r;
    logic [3:0][7:0] out_r;
    logic [3:0][7:0] oe_r;
    logic [3:0][7:0] fast_r;
    logic [7:0] mcell_ab_r;
    logic [7:0] mcell_bc_r;
    logic [7:0] mask_ab_r;
    logic [7:0] mask_bc_r;
    logic [7:0] rdata_nxt;
    logic [7:0] rdata_r;
    logic dbe_r;
    logic wr;
    logic rd;
    logic [1:0] aport;
    logic [7:0] aofs;
    logic wr_omc_a;
    logic wr_omc_bc;
    logic [7:0] ld_ab;
    logic [7:0] ld_bc;

    assign pin_raw = {5'h00, port_d_pin_in, port_c_pin_in,
        port_b_pin_in, port_a_pin_in};
    assign pld_oe = {5'h00, pld_oe_d, pld_oe_c, pld_oe_b, pld_oe_a};
    assign lat_addr = {8'h00, 8'h00, lat_addr_b, lat_addr_a};

    // Address decode inside the I/O register block
    assign wr = io_register_block_select & bus_wr;
    assign rd = io_register_block_select & bus_rd;
    assign aport = {bus_addr[4], bus_addr[0]};
    assign aofs = bus_addr & ~iop_pkg::PORT_SEL;
    assign wr_omc_a = wr && aofs == iop_pkg::OFS_OMC
        && aport == iop_pkg::PORT_A;
    assign wr_omc_bc = wr && aofs == iop_pkg::OFS_OMC
        && (aport == iop_pkg::PORT_B || aport == iop_pkg::PORT_C);
    assign ld_ab = {8{wr_omc_a}} & ~mask_ab_r;
    assign ld_bc = {8{wr_omc_bc}} & ~mask_bc_r;

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
        end
        else
        begin
            sync1_r <= pin_raw;
            sync2_r <= sync1_r;
        end
    end

    genvar p;
    genvar b;
    generate
        for (p = 0; p < 4; p++)
        begin : g_port
            always_ff @(posedge mclk or posedge reset)
            begin
                if (reset)
                begin
                    mode_r[p] <= iop_pkg::RESET_VAL;
                    dir_r[p] <= iop_pkg::RESET_VAL;
                    drive_r[p] <= iop_pkg::RESET_VAL;
                    dout_r[p] <= iop_pkg::RESET_VAL;
                end
                else if (wr && aport == 2'(p))
                begin
                    case (aofs)
                        iop_pkg::OFS_MODE:
                            mode_r[p] <= bus_wdata
                                & iop_pkg::MODE_MASK[p];
                        iop_pkg::OFS_DIR:
                            dir_r[p] <= bus_wdata
                                & iop_pkg::PIN_MASK[p];
                        iop_pkg::OFS_DRIVE:
                            drive_r[p] <= bus_wdata
                                & (iop_pkg::SLEW_MASK[p]
                                | iop_pkg::OD_MASK[p]);
                        iop_pkg::OFS_DATA_OUT:
                            dout_r[p] <= bus_wdata
                                & iop_pkg::PIN_MASK[p];
                        default:
                            dout_r[p] <= dout_r[p];
                    endcase
                end
            end

            // Input macrocells follow pins while enabled, else hold
            always_ff @(posedge mclk or posedge reset)
            begin
                if (reset)
                    imc_r[p] <= '0;
                else if (imc_latch_en)
                    imc_r[p] <= sync2_r[p] & iop_pkg::MC_MASK[p];
            end

            for (b = 0; b < 8; b++)
            begin : g_pin
                logic mc_sel;
                logic mc_val;
                logic src;
                logic en;
                logic od;
                always_comb
                begin
                    mc_sel = 1'b0;
                    mc_val = 1'b0;
                    case (p)
                        0:
                        begin
                            mc_sel = route_ab_to_a[b];
                            mc_val = mcell_ab_r[b];
                        end
                        1:
                        begin
                            mc_sel = route_ab_to_b[b] | route_bc_to_b[b];
                            mc_val = route_ab_to_b[b] ? mcell_ab_r[b]
                                : mcell_bc_r[b];
                        end
                        2:
                        begin
                            mc_sel = route_bc_to_c[b];
                            mc_val = mcell_bc_r[b];
                        end
                        default:
                        begin
                            mc_sel = 1'b0;
                            mc_val = 1'b0;
                        end
                    endcase
                    if (mode_r[p][b])
                        src = lat_addr[p][b];
                    else if (mc_sel)
                        src = mc_val;
                    else
                        src = dout_r[p][b];
                    en = dir_r[p][b] | pld_oe[p][b];
                    od = drive_r[p][b] & iop_pkg::OD_MASK[p][b];
                    if (p == 2 && jtag_enable)
                    begin
                        src = jtag_out[b];
                        en = jtag_oe[b];
                        od = 1'b0;
                    end
                    else if (p == 2 && b == iop_pkg::PIN_C_BATT
                        && batt_ind_enable)
                    begin
                        src = supply_below_battery;
                        en = 1'b1;
                    end
                    en = en & iop_pkg::PIN_MASK[p][b];
                end

                // Pin drivers, one per bit of the port
                always_ff @(posedge mclk or posedge reset)
                begin
                    if (reset)
                    begin
                        en_r[p][b] <= 1'b0;
                        oe_r[p][b] <= 1'b0;
                        out_r[p][b] <= 1'b0;
                        fast_r[p][b] <= 1'b0;
                    end
                    else
                    begin
                        en_r[p][b] <= en;
                        oe_r[p][b] <= en & ~(od & src);
                        out_r[p][b] <= src & ~od;
                        fast_r[p][b] <= drive_r[p][b]
                            & iop_pkg::SLEW_MASK[p][b];
                    end
                end
            end
        end
    endgenerate

    // Output macrocell flip-flops: MCU load beats PLD load
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            mcell_ab_r <= '0;
            mcell_bc_r <= '0;
        end
        else
        begin
            mcell_ab_r <= (ld_ab & bus_wdata) | (~ld_ab
                & (pld_ab_load ? pld_ab_next : mcell_ab_r));
            mcell_bc_r <= (ld_bc & bus_wdata) | (~ld_bc
                & (pld_bc_load ? pld_bc_next : mcell_bc_r));
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            mask_ab_r <= iop_pkg::RESET_VAL;
            mask_bc_r <= iop_pkg::RESET_VAL;
        end
        else if (wr && aofs == iop_pkg::OFS_MASK)
        begin
            if (aport == iop_pkg::PORT_A)
                mask_ab_r <= bus_wdata;
            else if (aport != iop_pkg::PORT_D)
                mask_bc_r <= bus_wdata;
        end
    end

    always_comb
    begin
        rdata_nxt = '0;
        case (aofs)
            iop_pkg::OFS_DATA_IN:
                rdata_nxt = sync2_r[aport];
            iop_pkg::OFS_MODE:
                rdata_nxt = mode_r[aport];
            iop_pkg::OFS_DIR:
                rdata_nxt = dir_r[aport];
            iop_pkg::OFS_DRIVE:
                rdata_nxt = drive_r[aport];
            iop_pkg::OFS_DATA_OUT:
                rdata_nxt = dout_r[aport];
            iop_pkg::OFS_IMC:
                rdata_nxt = imc_r[aport];
            iop_pkg::OFS_ENABLE:
                rdata_nxt = en_r[aport]
                    & iop_pkg::MC_MASK[aport];
            iop_pkg::OFS_OMC:
                rdata_nxt = aport == iop_pkg::PORT_A ? mcell_ab_r
                    : aport == iop_pkg::PORT_D ? 8'h00
                    : mcell_bc_r;
            iop_pkg::OFS_MASK:
                rdata_nxt = aport == iop_pkg::PORT_A ? mask_ab_r
                    : aport == iop_pkg::PORT_D ? 8'h00 : mask_bc_r;
            default:
                rdata_nxt = '0;
        endcase
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            rdata_r <= '0;
        else if (rd)
            rdata_r <= rdata_nxt;
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            dbe_r <= 1'b0;
        else
            dbe_r <= dbe_enable
                & sync2_r[iop_pkg::PORT_C][iop_pkg::PIN_C_DBE];
    end

    assign bus_rdata = rdata_r;
    assign port_a_pin_out = out_r[0];
    assign port_b_pin_out = out_r[1];
    assign port_c_pin_out = out_r[2];
    assign port_d_pin_out = out_r[3][2:0];
    assign port_a_pin_oe = oe_r[0];
    assign port_b_pin_oe = oe_r[1];
    assign port_c_pin_oe = oe_r[2];
    assign port_d_pin_oe = oe_r[3][2:0];
    assign port_a_fast_slew = fast_r[0];
    assign port_b_fast_slew = fast_r[1];
    assign port_d_fast_slew = fast_r[3][2:0];
    assign input_macrocell_bus = {imc_r[2], imc_r[1], imc_r[0]};
    assign macrocell_group_ab = mcell_ab_r;
    assign macrocell_group_bc = mcell_bc_r;
    assign jtag_in = imc_r[2];
    assign port_c_pin_seven = dbe_r;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    a_dir_write: assert property (wr && aofs == iop_pkg::OFS_DIR
        && aport == iop_pkg::PORT_A |=> dir_r[0] == $past(bus_wdata))
        else $error("direction write not stored");
    a_portd_dir: assert property (dir_r[3][7:3] == 5'h00)
        else $error("port d upper direction bits set");
    a_mode_cd: assert property (mode_r[2] == 8'h00
        && mode_r[3] == 8'h00)
        else $error("mode bits on port c or d");
    a_oe_or: assert property (en_r[1] == $past(dir_r[1] | pld_oe_b))
        else $error("port b enable not direction or pld term");
    a_od_low: assert property ((oe_r[0][7:4]
        & $past(drive_r[0][7:4]) & out_r[0][7:4]) == 4'h0)
        else $error("open drain pin driven high");
    a_mask_blocks: assert property (wr_omc_a && mask_ab_r == 8'hff
        && !pld_ab_load |=> $stable(mcell_ab_r))
        else $error("masked macrocell loaded");
    a_omc_load: assert property (wr_omc_a && mask_ab_r == 8'h00
        |=> mcell_ab_r == $past(bus_wdata))
        else $error("unmasked macrocell not loaded");
    a_read_dout: assert property (rd && aofs == iop_pkg::OFS_DATA_OUT
        && aport == iop_pkg::PORT_A
        |=> bus_rdata == $past(dout_r[0]))
        else $error("data out readback wrong");
    a_read_din: assert property (rd && aofs == iop_pkg::OFS_DATA_IN
        && aport == iop_pkg::PORT_B
        |=> bus_rdata == $past(sync2_r[1]))
        else $error("data in read wrong");
    c_addr_out: cover property (mode_r[0] != 8'h00 && oe_r[0] != 8'h00);
    c_masked_wr: cover property (wr_omc_bc && mask_bc_r != 8'h00);
    c_jtag: cover property (jtag_enable && oe_r[2] != 8'h00);
endmodule : iop_port_regs

// *** iop_pkg.sv ***
package iop_pkg;
    // Register offsets within one port's window
    localparam logic [7:0] OFS_DATA_IN = 8'h00;
    localparam logic [7:0] OFS_MODE = 8'h02;
    localparam logic [7:0] OFS_DATA_OUT = 8'h04;
    localparam logic [7:0] OFS_DIR = 8'h06;
    localparam logic [7:0] OFS_DRIVE = 8'h08;
    localparam logic [7:0] OFS_IMC = 8'h0a;
    localparam logic [7:0] OFS_ENABLE = 8'h0c;
    localparam logic [7:0] OFS_OMC = 8'h20;
    localparam logic [7:0] OFS_MASK = 8'h22;
    // Port select bits, port index = {addr[4], addr[0]}
    localparam logic [7:0] PORT_SEL = 8'h11;
    localparam logic [1:0] PORT_A = 2'h0;
    localparam logic [1:0] PORT_B = 2'h1;
    localparam logic [1:0] PORT_C = 2'h2;
    localparam logic [1:0] PORT_D = 2'h3;
    localparam logic [7:0] RESET_VAL = 8'h00;
    // Per port bit masks, index 3 is port D
    localparam logic [3:0][7:0] PIN_MASK = {8'h07, 8'hff, 8'hff, 8'hff};
    localparam logic [3:0][7:0] MODE_MASK = {8'h00, 8'h00, 8'hff, 8'hff};
    localparam logic [3:0][7:0] SLEW_MASK = {8'h07, 8'h00, 8'h0f, 8'h0f};
    localparam logic [3:0][7:0] OD_MASK = {8'h00, 8'hff, 8'hf0, 8'hf0};
    localparam logic [3:0][7:0] MC_MASK = {8'h00, 8'hff, 8'hff, 8'hff};
    localparam int PIN_C_BATT = 4;
    localparam int PIN_C_DBE = 7;
endpackage : iop_pkg

// *** iop_pin_model.sv ***
`timescale 1ns/10ps
module iop_pin_model #(
    parameter int W = 8
) (
    input wire logic [W-1:0] drv_val,
    input wire logic [W-1:0] drv_en,
    input wire logic [W-1:0] ext_val,
    input wire logic [W-1:0] ext_en,
    output logic [W-1:0] level
);
    // Device driver wins; undriven pins float high on the pull-up
    always_comb
    begin
        for (int i = 0; i < W; i++)
        begin
            if (drv_en[i])
                level[i] = drv_val[i];
            else if (ext_en[i])
                level[i] = ext_val[i];
            else
                level[i] = 1'b1;
        end
    end
endmodule : iop_pin_model

// *** io_port_config_and_data_regs_tb.sv ***
`timescale 1ns/10ps
module io_port_config_and_data_regs_tb;
    localparam logic [7:0] BA = 8'h00, BB = 8'h01, BC = 8'h10, BD = 8'h11;
    localparam logic [7:0] DIN = iop_pkg::OFS_DATA_IN;
    localparam logic [7:0] MODE = iop_pkg::OFS_MODE;
    localparam logic [7:0] DOUT = iop_pkg::OFS_DATA_OUT;
    localparam logic [7:0] DIR = iop_pkg::OFS_DIR;
    localparam logic [7:0] DRV = iop_pkg::OFS_DRIVE;
    localparam logic [7:0] INPUT_MACROCELL = iop_pkg::OFS_IMC;
    localparam logic [7:0] ENA = iop_pkg::OFS_ENABLE;
    localparam logic [7:0] OUTPUT_MACROCELL = iop_pkg::OFS_OMC;
    localparam logic [7:0] MASK = iop_pkg::OFS_MASK;
    logic mclk, reset, io_register_block_select, bus_wr, bus_rd;
    logic [7:0] bus_addr, bus_wdata, bus_rdata, ext_b_val, ext_b_en;
    logic [7:0] port_a_pin_in, port_b_pin_in, port_c_pin_in;
    logic [7:0] port_a_pin_out, port_b_pin_out, port_c_pin_out;
    logic [7:0] port_a_pin_oe, port_b_pin_oe, port_c_pin_oe;
    logic [2:0] port_d_pin_in, port_d_pin_out, port_d_pin_oe;
    logic [2:0] port_d_fast_slew, pld_oe_d;
    logic [7:0] port_a_fast_slew, port_b_fast_slew;
    logic [7:0] pld_oe_a, pld_oe_b, pld_oe_c, lat_addr_a, lat_addr_b;
    logic [7:0] pld_ab_next, pld_bc_next, route_ab_to_a, route_ab_to_b;
    logic [7:0] route_bc_to_b, route_bc_to_c, jtag_out, jtag_oe, jtag_in;
    logic [7:0] macrocell_group_ab, macrocell_group_bc;
    logic [23:0] input_macrocell_bus;
    logic pld_ab_load, pld_bc_load, imc_latch_en, jtag_enable, dbe_enable;
    logic port_c_pin_seven, batt_ind_enable, supply_below_battery;
    int mismatches, comparisons;
    logic [7:0] ext_a_val, ext_a_en, ext_c_val, ext_c_en;
    logic [2:0] ext_d_val, ext_d_en;

    iop_port_regs i_dut (
        .mclk, .reset, .io_register_block_select, .bus_addr, .bus_wr,
        .bus_rd, .bus_wdata, .bus_rdata, .port_a_pin_in, .port_b_pin_in,
        .port_c_pin_in, .port_d_pin_in, .port_a_pin_out, .port_b_pin_out,
        .port_c_pin_out, .port_d_pin_out, .port_a_pin_oe, .port_b_pin_oe,
        .port_c_pin_oe, .port_d_pin_oe, .port_a_fast_slew,
        .port_b_fast_slew, .port_d_fast_slew, .pld_oe_a, .pld_oe_b,
        .pld_oe_c, .pld_oe_d, .lat_addr_a, .lat_addr_b, .pld_ab_next,
        .pld_ab_load, .pld_bc_next, .pld_bc_load, .route_ab_to_a,
        .route_ab_to_b, .route_bc_to_b, .route_bc_to_c, .imc_latch_en,
        .input_macrocell_bus, .macrocell_group_ab, .macrocell_group_bc,
        .jtag_enable, .jtag_out, .jtag_oe, .jtag_in, .dbe_enable,
        .port_c_pin_seven, .batt_ind_enable, .supply_below_battery
    );
    iop_pin_model #(.W(8)) i_pa (.drv_val(port_a_pin_out),
        .drv_en(port_a_pin_oe), .ext_val(ext_a_val), .ext_en(ext_a_en),
        .level(port_a_pin_in));
    iop_pin_model #(.W(8)) i_pb (.drv_val(port_b_pin_out),
        .drv_en(port_b_pin_oe), .ext_val(ext_b_val), .ext_en(ext_b_en),
        .level(port_b_pin_in));
    iop_pin_model #(.W(8)) i_pc (.drv_val(port_c_pin_out),
        .drv_en(port_c_pin_oe), .ext_val(ext_c_val), .ext_en(ext_c_en),
        .level(port_c_pin_in));
    iop_pin_model #(.W(3)) i_pd (.drv_val(port_d_pin_out),
        .drv_en(port_d_pin_oe), .ext_val(ext_d_val), .ext_en(ext_d_en),
        .level(port_d_pin_in));

    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        io_register_block_select = 1'b1;
        bus_wr = 1'b1;
        bus_addr = a;
        bus_wdata = d;
        @(negedge mclk);
        io_register_block_select = 1'b0;
        bus_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge mclk);
        io_register_block_select = 1'b1;
        bus_rd = 1'b1;
        bus_addr = a;
        @(negedge mclk);
        io_register_block_select = 1'b0;
        bus_rd = 1'b0;
        chk(bus_rdata, exp);
    endtask : rd

    task automatic settle(input int n);
        repeat (n) @(negedge mclk);
    endtask : settle

    task automatic t_reset();
        logic [7:0] b [4] = '{BA, BB, BC, BD};
        for (int i = 0; i < 4; i++)
        begin
            rd(b[i] | MODE, 8'h00);
            rd(b[i] | DIR, 8'h00);
            rd(b[i] | DRV, 8'h00);
            rd(b[i] | MASK, 8'h00);
        end
        chk({port_a_pin_oe, port_b_pin_oe, port_c_pin_oe}, 24'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_dir();
        wr(BA | DOUT, 8'ha5);
        wr(BA | DIR, 8'h07);
        settle(1);
        chk(port_a_pin_oe, 8'h07);
        chk(port_a_pin_out & 8'h07, 8'h05);
        rd(BA | DOUT, 8'ha5);
        pld_oe_a = 8'h80;
        settle(2);
        chk(port_a_pin_oe, 8'h87);
        rd(BA | ENA, 8'h87);
        pld_oe_a = 8'h00;
        wr(BA | DIR, 8'h00);
        wr(BD | DIR, 8'hff);
        rd(BD | DIR, 8'h07);
        chk(port_d_pin_oe, 3'h7);
        wr(BD | DIR, 8'h00);
        rd(BA | ENA, 8'h00);
        $display("test direction done");
    endtask : t_dir

    task automatic t_drive();
        wr(BA | DRV, 8'hff);
        wr(BD | DRV, 8'hff);
        settle(1);
        chk(port_a_fast_slew, 8'h0f);
        chk(port_d_fast_slew, 3'h7);
        rd(BD | DRV, 8'h07);
        wr(BC | DOUT, 8'h0f);
        wr(BC | DIR, 8'hff);
        wr(BC | DRV, 8'hff);
        settle(1);
        chk(port_c_pin_oe, 8'hf0);
        chk(port_c_pin_out, 8'h00);
        settle(2);
        rd(BC | DIN, 8'h0f);
        wr(BC | DRV, 8'h00);
        settle(1);
        chk(port_c_pin_oe, 8'hff);
        chk(port_c_pin_out, 8'h0f);
        wr(BC | DIR, 8'h00);
        $display("test drive done");
    endtask : t_drive

    task automatic t_mode();
        lat_addr_a = 8'h3c;
        wr(BA | DOUT, 8'h00);
        wr(BA | MODE, 8'h0f);
        wr(BA | DIR, 8'hff);
        settle(1);
        chk(port_a_pin_out, 8'h0c);
        rd(BA | MODE, 8'h0f);
        wr(BC | MODE, 8'hff);
        rd(BC | MODE, 8'h00);
        wr(BA | MODE, 8'h00);
        settle(1);
        chk(port_a_pin_out, 8'h00);
        $display("test mode done");
    endtask : t_mode

    task automatic t_cells();
        wr(BA | MASK, 8'hf0);
        wr(BA | OUTPUT_MACROCELL, 8'hff);
        chk(macrocell_group_ab, 8'h0f);
        rd(BA | OUTPUT_MACROCELL, 8'h0f);
        route_ab_to_a = 8'hff;
        settle(2);
        chk(port_a_pin_out, 8'h0f);
        route_ab_to_a = 8'h00;
        wr(BA | DIR, 8'h00);
        ext_b_val = 8'h5a;
        ext_b_en = 8'hff;
        imc_latch_en = 1'b1;
        settle(4);
        chk(input_macrocell_bus[15:8], 8'h5a);
        rd(BB | INPUT_MACROCELL, 8'h5a);
        rd(BB | DIN, 8'h5a);
        imc_latch_en = 1'b0;
        $display("test cells done");
    endtask : t_cells

    task automatic t_bc();
        ext_c_val = 8'h96;
        ext_c_en = 8'hff;
        ext_d_val = 3'h5;
        ext_d_en = 3'h7;
        wr(BB | MASK, 8'h0f);
        rd(BC | MASK, 8'h0f);
        wr(BC | OUTPUT_MACROCELL, 8'ha5);
        chk(macrocell_group_bc, 8'ha0);
        pld_bc_next = 8'h3c;
        pld_bc_load = 1'b1;
        settle(1);
        pld_bc_load = 1'b0;
        chk(macrocell_group_bc, 8'h3c);
        {route_ab_to_b, route_bc_to_b, route_bc_to_c} = 24'h0fffff;
        wr(BB | DIR, 8'hff);
        wr(BB | DRV, 8'h33);
        wr(BD | DOUT, 8'hff);
        settle(1);
        chk(port_b_pin_out, 8'h0f);
        chk(port_b_pin_oe, 8'hcf);
        chk(port_b_fast_slew, 8'h03);
        chk(port_c_pin_out, 8'h3c);
        chk(port_d_pin_out, 3'h7);
        rd(BD | DOUT, 8'h07);
        rd(BD | DIN, 8'h05);
        imc_latch_en = 1'b1;
        settle(4);
        imc_latch_en = 1'b0;
        chk(jtag_in, 8'h96);
        batt_ind_enable = 1'b1;
        settle(1);
        chk(port_c_pin_oe, 8'h10);
        chk(port_c_pin_out, 8'h2c);
        batt_ind_enable = 1'b0;
        {route_ab_to_b, route_bc_to_b, route_bc_to_c} = 24'h0;
        $display("test groups done");
    endtask : t_bc

    task automatic t_misc();
        rd(8'h0e, 8'h00);
        jtag_out = 8'h55;
        jtag_oe = 8'hff;
        jtag_enable = 1'b1;
        settle(2);
        chk(port_c_pin_out, 8'h55);
        chk(port_c_pin_oe, 8'hff);
        jtag_enable = 1'b0;
        dbe_enable = 1'b1;
        settle(5);
        chk(port_c_pin_seven, 1'b1);
        dbe_enable = 1'b0;
        settle(2);
        chk(port_c_pin_seven, 1'b0);
        dbe_enable = 1'b1;
        ext_c_val = 8'h00;
        settle(4);
        chk(port_c_pin_seven, 1'b0);
        $display("test misc done");
    endtask : t_misc

    initial
    begin
        {reset, io_register_block_select, bus_wr, bus_rd} = 4'hf;
        {io_register_block_select, bus_wr, bus_rd} = 3'h0;
        {bus_addr, bus_wdata, ext_b_val, ext_b_en} = 32'h0;
        {ext_a_val, ext_a_en, ext_c_val, ext_c_en} = 32'h0;
        {ext_d_val, ext_d_en} = 6'h0;
        {pld_oe_a, pld_oe_b, pld_oe_c, pld_oe_d} = 27'h0;
        {lat_addr_a, lat_addr_b, pld_ab_next, pld_bc_next} = 32'h0;
        {route_ab_to_a, route_ab_to_b, route_bc_to_b} = 24'h0;
        {route_bc_to_c, jtag_out, jtag_oe} = 24'h0;
        {pld_ab_load, pld_bc_load, imc_latch_en, jtag_enable} = 4'h0;
        {dbe_enable, batt_ind_enable, supply_below_battery} = 3'h0;
        mismatches = 0;
        comparisons = 0;
        settle(3);
        reset = 1'b0;
        t_reset();
        t_dir();
        t_drive();
        t_mode();
        t_cells();
        t_bc();
        t_misc();
        give_verdict();
    end

    initial
    begin
        repeat (3000) @(posedge mclk);
        mismatches++;
        give_verdict();
    end
endmodule : io_port_config_and_data_regs_tb
